// ===== logic/trsv_consts.svh
`ifndef TRSV_CONSTS_SVH
`define TRSV_CONSTS_SVH

// ****************************************
// Sizes
// ****************************************
`define TRSV_NCH        2
`define TRSV_NDI        16
`define TRSV_SYNC_W     22
`define TRSV_IRQ_W      4
`define TRSV_CTRL_W     15
`define TRSV_DLY_W      10
`define TRSV_PRESC_W    20
`define TRSV_ADDR_W     12

// ****************************************
// Timing
// ****************************************
`define TRSV_CLK_MHZ    100
`define TRSV_TICK_US    10000
`define TRSV_DELAY_MIN  10'h00A
`define TRSV_DELAY_MAX  10'h3E8
`define TRSV_DELAY_DEF  10'h014

// ****************************************
// Register offsets
// ****************************************
`define TRSV_OFF_CTRL0  12'h000
`define TRSV_OFF_DELAY0 12'h004
`define TRSV_CH_STRIDE  12'h008
`define TRSV_OFF_STATUS 12'h010
`define TRSV_OFF_IRQST  12'h014
`define TRSV_OFF_IRQMSK 12'h018

// ****************************************
// Control fields and reset values
// ****************************************
`define TRSV_F_EN       0
`define TRSV_F_MODE     1
`define TRSV_F_PERMIT   2
`define TRSV_F_POS_HI   4
`define TRSV_F_POS_LO   3
`define TRSV_F_IN1_HI   9
`define TRSV_F_IN1_LO   5
`define TRSV_F_IN2_HI   14
`define TRSV_F_IN2_LO   10
`define TRSV_CTRL_RST   15'h0000
`define TRSV_POS_NONE   2'h0
`define TRSV_POS_SG1    2'h1
`define TRSV_POS_SG2    2'h2
`define TRSV_SEL_NONE   5'h00
`define TRSV_SEL_ONE    5'h01

// ****************************************
// Synchroniser bit positions
// ****************************************
`define TRSV_S_DI_LO    0
`define TRSV_S_SG1      16
`define TRSV_S_SG2      17
`define TRSV_S_EB1_LO   18
`define TRSV_S_EB2_LO   20

`endif

// ===== logic/trsv_pkg.sv
`include "trsv_consts.svh"

package trsv_pkg;

  typedef enum logic [1:0] {
    TRSV_IDLE,
    TRSV_WATCH,
    TRSV_TIMING,
    TRSV_ALARM
  } trsv_state_t;

  typedef struct packed {
    trsv_state_t                 st;
    logic [`TRSV_PRESC_W-1:0]    presc;
    logic [`TRSV_DLY_W-1:0]      ticks;
    logic                        alarm;
    logic                        active;
    logic                        ext_blocked;
    logic                        not_possible;
  } trsv_chan_st_t;

  typedef struct packed {
    logic [`TRSV_NCH-1:0][`TRSV_CTRL_W-1:0] ctrl;
    logic [`TRSV_NCH-1:0][`TRSV_DLY_W-1:0]  delay;
    logic [`TRSV_IRQ_W-1:0]                 irq_stat;
    logic [`TRSV_IRQ_W-1:0]                 irq_mask;
    logic [`TRSV_NCH-1:0]                   alarm_prev;
    logic [`TRSV_NCH-1:0]                   np_prev;
    logic [`TRSV_SYNC_W-1:0]                sync1;
    logic [`TRSV_SYNC_W-1:0]                sync2;
    logic [31:0]                            prdata;
    logic                                   pslverr;
  } trsv_top_st_t;

endpackage

// ===== logic/trsv_chan_if.sv
`timescale 1ns/1ps
`include "trsv_consts.svh"

interface trsv_chan_if;
  logic                   enable;
  logic                   mode_either;
  logic                   block_permit;
  logic [1:0]             breaker_position_source;
  logic [`TRSV_DLY_W-1:0] supervision_delay;
  logic                   supervise_one;
  logic                   supervise_two;
  logic                   switchgear_one_position;
  logic                   switchgear_two_position;
  logic                   external_block_one;
  logic                   external_block_two;
  logic                   active;
  logic                   ext_blocked;
  logic                   alarm;
  logic                   not_possible;

  modport cfg (
    output enable, mode_either, block_permit, breaker_position_source,
    output supervision_delay, supervise_one, supervise_two,
    output switchgear_one_position, switchgear_two_position,
    output external_block_one, external_block_two,
    input  active, ext_blocked, alarm, not_possible
  );

  modport sup (
    input  enable, mode_either, block_permit, breaker_position_source,
    input  supervision_delay, supervise_one, supervise_two,
    input  switchgear_one_position, switchgear_two_position,
    input  external_block_one, external_block_two,
    output active, ext_blocked, alarm, not_possible
  );
endinterface

// ===== logic/trsv_channel.sv
`timescale 1ns/1ps
`include "trsv_consts.svh"

module trsv_channel #(
  parameter int TICK_CYCLES = `TRSV_TICK_US * `TRSV_CLK_MHZ
) (
  input wire logic  pclk,    // System clock
  input wire logic  presetn, // Async reset, active low
  trsv_chan_if.sup  ch       // Settings in, status out
);

  trsv_pkg::trsv_chan_st_t r;
  trsv_pkg::trsv_chan_st_t next_r;

  logic np;
  logic blocked;
  logic closed;
  logic fault;
  logic run;
  logic wrap;

  // ****************************************
  // Supervision logic
  // ****************************************
  always_comb
  begin
    next_r = r;
    np = (ch.breaker_position_source != `TRSV_POS_SG1) &&
         (ch.breaker_position_source != `TRSV_POS_SG2);
    blocked = ch.enable & ch.block_permit &
              (ch.external_block_one | ch.external_block_two);
    closed = (ch.breaker_position_source == `TRSV_POS_SG1) ?
             ch.switchgear_one_position :
             ch.switchgear_two_position;
    // Open breaker is only looked at with the second contact in use
    fault = closed ? ~ch.supervise_one :
            (ch.mode_either & ~ch.supervise_two);
    run = ch.enable & ~np & ~blocked;
    wrap = (r.presc == `TRSV_PRESC_W'(TICK_CYCLES - 1));
    case (r.st)
      trsv_pkg::TRSV_IDLE:
      begin
        if (run)
          next_r.st = trsv_pkg::TRSV_WATCH;
      end
      trsv_pkg::TRSV_WATCH:
      begin
        next_r.presc = '0;
        next_r.ticks = '0;
        if (!run)
          next_r.st = trsv_pkg::TRSV_IDLE;
        else if (fault)
          next_r.st = trsv_pkg::TRSV_TIMING;
      end
      trsv_pkg::TRSV_TIMING:
      begin
        if (!run)
          next_r.st = trsv_pkg::TRSV_IDLE;
        else if (!fault)
          next_r.st = trsv_pkg::TRSV_WATCH;
        else if (wrap)
        begin
          next_r.presc = '0;
          next_r.ticks = r.ticks + `TRSV_DLY_W'(1);
          if (r.ticks + `TRSV_DLY_W'(1) >= ch.supervision_delay)
            next_r.st = trsv_pkg::TRSV_ALARM;
        end
        else
          next_r.presc = r.presc + `TRSV_PRESC_W'(1);
      end
      trsv_pkg::TRSV_ALARM:
      begin
        if (!run)
          next_r.st = trsv_pkg::TRSV_IDLE;
        else if (!fault)
          next_r.st = trsv_pkg::TRSV_WATCH;
      end
      default:
        next_r.st = trsv_pkg::TRSV_IDLE;
    endcase
    next_r.alarm = (next_r.st == trsv_pkg::TRSV_ALARM);
    next_r.active = ch.enable & ~np;
    next_r.ext_blocked = blocked;
    next_r.not_possible = ch.enable & np;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r.st <= trsv_pkg::TRSV_IDLE;
      r.presc <= '0;
      r.ticks <= '0;
      r.alarm <= 1'b0;
      r.active <= 1'b0;
      r.ext_blocked <= 1'b0;
      r.not_possible <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign ch.alarm = r.alarm;
  assign ch.active = r.active;
  assign ch.ext_blocked = r.ext_blocked;
  assign ch.not_possible = r.not_possible;

endmodule

// ===== logic/trsv_top.sv
// Chosen here: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`include "trsv_consts.svh"

module trsv_top #(
  parameter int TICK_CYCLES = `TRSV_TICK_US * `TRSV_CLK_MHZ
) (
  input  wire logic                      pclk,                    // Clock
  input  wire logic                      presetn,                 // Reset
  input  wire logic                      psel,                    // APB
  input  wire logic                      penable,                 // APB
  input  wire logic                      pwrite,                  // APB
  input  wire logic [`TRSV_ADDR_W-1:0]   paddr,                   // APB
  input  wire logic [31:0]               pwdata,                  // APB
  output logic      [31:0]               prdata,                  // APB
  output logic                           pready,                  // APB
  output logic                           pslverr,                 // APB
  input  wire logic [`TRSV_NDI-1:0]      digital_in,              // Pins
  input  wire logic                      switchgear_one_position, // Closed
  input  wire logic                      switchgear_two_position, // Closed
  input  wire logic [`TRSV_NCH-1:0]      external_block_one,      // Per ch
  input  wire logic [`TRSV_NCH-1:0]      external_block_two,      // Per ch
  output logic      [`TRSV_NCH-1:0]      alarm,                   // Alarm
  output logic      [`TRSV_NCH-1:0]      active,                  // Running
  output logic      [`TRSV_NCH-1:0]      ext_blocked,             // Blocked
  output logic      [`TRSV_NCH-1:0]      not_possible,            // No pos
  output logic                           irq                      // Level
);

  trsv_pkg::trsv_top_st_t r;
  trsv_pkg::trsv_top_st_t next_r;

  logic [`TRSV_SYNC_W-1:0] raw_in;
  logic [`TRSV_NCH-1:0]    ch_alarm;
  logic [`TRSV_NCH-1:0]    ch_active;
  logic [`TRSV_NCH-1:0]    ch_blocked;
  logic [`TRSV_NCH-1:0]    ch_np;
  logic [`TRSV_NDI-1:0]    di_s;
  logic                    setup;
  logic                    access;
  logic [`TRSV_IRQ_W-1:0]  events;
  logic [`TRSV_IRQ_W-1:0]  w1c;
  logic [31:0]             rd;
  logic                    hit;

  assign raw_in = {external_block_two, external_block_one,
                   switchgear_two_position, switchgear_one_position,
                   digital_in};
  assign di_s = r.sync2[`TRSV_S_DI_LO +: `TRSV_NDI];

  // Unassigned input reads low, which counts as a broken circuit
  function automatic logic pick_di(
    input logic [`TRSV_NDI-1:0] di,
    input logic [4:0]           sel
  );
    logic [3:0] idx;
    idx = 4'(sel - `TRSV_SEL_ONE);
    pick_di = (sel == `TRSV_SEL_NONE) ? 1'b0 : di[idx];
  endfunction

  // Out-of-range delays are clamped so a channel never times out in under 10 ticks
  function automatic logic [`TRSV_DLY_W-1:0] clamp_delay(
    input logic [31:0] v
  );
    if (v < 32'(`TRSV_DELAY_MIN))
      clamp_delay = `TRSV_DELAY_MIN;
    else if (v > 32'(`TRSV_DELAY_MAX))
      clamp_delay = `TRSV_DELAY_MAX;
    else
      clamp_delay = v[`TRSV_DLY_W-1:0];
  endfunction

  // ****************************************
  // Supervision channels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < `TRSV_NCH; g++)
    begin : g_ch
      trsv_chan_if ch_if ();

      assign ch_if.enable = r.ctrl[g][`TRSV_F_EN];
      assign ch_if.mode_either = r.ctrl[g][`TRSV_F_MODE];
      assign ch_if.block_permit = r.ctrl[g][`TRSV_F_PERMIT];
      assign ch_if.breaker_position_source =
        r.ctrl[g][`TRSV_F_POS_HI:`TRSV_F_POS_LO];
      assign ch_if.supervision_delay = r.delay[g];
      assign ch_if.supervise_one =
        pick_di(di_s, r.ctrl[g][`TRSV_F_IN1_HI:`TRSV_F_IN1_LO]);
      assign ch_if.supervise_two =
        pick_di(di_s, r.ctrl[g][`TRSV_F_IN2_HI:`TRSV_F_IN2_LO]);
      assign ch_if.switchgear_one_position = r.sync2[`TRSV_S_SG1];
      assign ch_if.switchgear_two_position = r.sync2[`TRSV_S_SG2];
      assign ch_if.external_block_one = r.sync2[`TRSV_S_EB1_LO + g];
      assign ch_if.external_block_two = r.sync2[`TRSV_S_EB2_LO + g];
      assign ch_alarm[g] = ch_if.alarm;
      assign ch_active[g] = ch_if.active;
      assign ch_blocked[g] = ch_if.ext_blocked;
      assign ch_np[g] = ch_if.not_possible;

      trsv_channel #(
        .TICK_CYCLES (TICK_CYCLES)
      ) u_chan (
        .pclk    (pclk),
        .presetn (presetn),
        .ch      (ch_if.sup)
      );
    end
  endgenerate

  // ****************************************
  // APB slave, interrupts, synchronisers
  // ****************************************
  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign pready = access;

  always_comb
  begin
    next_r = r;
    next_r.sync1 = raw_in;
    next_r.sync2 = r.sync1;
    next_r.alarm_prev = ch_alarm;
    next_r.np_prev = ch_np;
    rd = 32'h0000_0000;
    hit = 1'b0;
    w1c = '0;
    for (int i = 0; i < `TRSV_NCH; i++)
    begin
      if (paddr == `TRSV_ADDR_W'(`TRSV_OFF_CTRL0 + i * `TRSV_CH_STRIDE))
      begin
        hit = 1'b1;
        rd = 32'(r.ctrl[i]);
        if (access && pwrite)
          next_r.ctrl[i] = pwdata[`TRSV_CTRL_W-1:0];
      end
      if (paddr == `TRSV_ADDR_W'(`TRSV_OFF_DELAY0 + i * `TRSV_CH_STRIDE))
      begin
        hit = 1'b1;
        rd = 32'(r.delay[i]);
        if (access && pwrite)
          next_r.delay[i] = clamp_delay(pwdata);
      end
    end
    if (paddr == `TRSV_OFF_STATUS)
    begin
      hit = 1'b1;
      rd = 32'({ch_np, ch_blocked, ch_active, ch_alarm});
    end
    if (paddr == `TRSV_OFF_IRQST)
    begin
      hit = 1'b1;
      rd = 32'(r.irq_stat);
      if (access && pwrite)
        w1c = pwdata[`TRSV_IRQ_W-1:0];
    end
    if (paddr == `TRSV_OFF_IRQMSK)
    begin
      hit = 1'b1;
      rd = 32'(r.irq_mask);
      if (access && pwrite)
        next_r.irq_mask = pwdata[`TRSV_IRQ_W-1:0];
    end
    // Read data is caught in setup so it leaves a flip-flop in access
    if (setup)
    begin
      next_r.prdata = rd;
      next_r.pslverr = ~hit;
    end
    // A new event beats a clear in the same cycle
    events = {ch_np & ~r.np_prev, ch_alarm & ~r.alarm_prev};
    next_r.irq_stat = (r.irq_stat & ~w1c) | events;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      for (int i = 0; i < `TRSV_NCH; i++)
      begin
        r.ctrl[i] <= `TRSV_CTRL_RST;
        r.delay[i] <= `TRSV_DELAY_DEF;
      end
      r.irq_stat <= '0;
      r.irq_mask <= '0;
      r.alarm_prev <= '0;
      r.np_prev <= '0;
      r.sync1 <= '0;
      r.sync2 <= '0;
      r.prdata <= 32'h0000_0000;
      r.pslverr <= 1'b0;
    end
    else
      r <= next_r;
  end

  assign prdata = r.prdata;
  assign pslverr = r.pslverr & access;
  assign alarm = ch_alarm;
  assign active = ch_active;
  assign ext_blocked = ch_blocked;
  assign not_possible = ch_np;
  assign irq = |(r.irq_stat & r.irq_mask);

endmodule

// ===== test/trsv_assertions.sv
`timescale 1ns/1ps
`include "trsv_consts.svh"

module trsv_assertions #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic                 pclk,               // Clock
  input wire logic                 presetn,            // Reset
  input wire logic                 psel,               // APB select
  input wire logic                 penable,            // APB enable
  input wire logic                 pready,             // APB ready
  input wire logic                 pslverr,            // APB error
  input wire logic [`TRSV_NCH-1:0] external_block_one, // Block one
  input wire logic [`TRSV_NCH-1:0] external_block_two, // Block two
  input wire logic [`TRSV_NCH-1:0] alarm,              // Alarm
  input wire logic [`TRSV_NCH-1:0] active,             // Running
  input wire logic [`TRSV_NCH-1:0] ext_blocked,        // Blocked
  input wire logic [`TRSV_NCH-1:0] not_possible        // No position
);
  // Two cycles of slack for skew between status flops and timer start
  localparam int MIN_RUN = `TRSV_DELAY_MIN * TICK_CYCLES - 2;
  int run0;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      run0 <= 0;
    else if (active[0] && !ext_blocked[0])
      run0 <= run0 + 1;
    else
      run0 <= 0;

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ****
  // Checks
  // ****
  chk_pready_access: assert property (psel && penable |-> pready)
    else $error("pready missing in access phase");
  chk_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access phase");
  chk_alarm_delay: assert property (
    $rose(alarm[0]) |-> run0 >= MIN_RUN)
    else $error("alarm rose before the supervision delay");
  chk_alarm_disable: assert property (
    !active[0] |-> ##[0:1] !alarm[0])
    else $error("alarm kept on inactive channel zero");
  chk_alarm_pair: assert property (
    !active[1] |-> ##[0:1] !alarm[1])
    else $error("alarm kept on inactive channel one");
  chk_np_exclusive: assert property (
    (active & not_possible) == 2'h0)
    else $error("active and not possible together");
  chk_block_idle: assert property (
    (!external_block_one[0] && !external_block_two[0])[*4]
      |-> !ext_blocked[0])
    else $error("blocked with no block input");
  chk_block_clears: assert property (
    ext_blocked[0] |-> ##[0:1] !alarm[0])
    else $error("alarm kept while blocked");

  cover property ($rose(alarm[0]));
  cover property ($rose(ext_blocked[0]));
  cover property ($rose(not_possible[1]));
  cover property (pslverr);
endmodule

bind trsv_top trsv_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_trsv_assertions (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pready(pready), .pslverr(pslverr),
  .external_block_one(external_block_one),
  .external_block_two(external_block_two),
  .alarm(alarm), .active(active), .ext_blocked(ext_blocked),
  .not_possible(not_possible)
);

// ===== test/trsv_breaker_model.sv
`timescale 1ns/1ps
`include "trsv_consts.svh"

module trsv_breaker_model #(
  parameter int GAP = 8
) (
  input  wire logic                 pclk,       // Clock
  input  wire logic [1:0]           cmd,        // Close command per breaker
  input  wire logic [1:0]           broken,     // Trip circuit wire broken
  output logic      [`TRSV_NDI-1:0] digital_in, // Coil current sensed
  output logic                      sg_one,     // Breaker zero closed
  output logic                      sg_two      // Breaker one closed
);
  logic [1:0] pos = 2'h0;
  int         cnt [2] = '{0, 0};
  logic [1:0] live;

  // Mid-travel both auxiliary contacts are open: no coil current
  always_ff @(posedge pclk)
    for (int i = 0; i < 2; i++)
      if (pos[i] == cmd[i])
        cnt[i] <= 0;
      else if (cnt[i] == GAP)
        pos[i] <= cmd[i];
      else
        cnt[i] <= cnt[i] + 1;

  assign live = ~broken & ~(pos ^ cmd);
  assign digital_in = {12'h000, live[1] & ~pos[1], live[1] & pos[1],
                       live[0] & ~pos[0], live[0] & pos[0]};
  assign sg_one = pos[0];
  assign sg_two = pos[1];
endmodule

// ===== test/test_trip_circuit_supervision.sv
`timescale 1ns/1ps
`include "trsv_consts.svh"

module test_trip_circuit_supervision;
  localparam int TICK = 4;
  localparam int DLY = `TRSV_DELAY_MIN * TICK;
  localparam int DLY1 = `TRSV_DELAY_DEF * TICK;
  localparam logic [11:0] CTRL1 = `TRSV_OFF_CTRL0 + `TRSV_CH_STRIDE;

  logic        pclk;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, irq, err, sg_one, sg_two;
  logic [15:0] digital_in;
  logic [1:0]  ext_one = 2'h0;
  logic [1:0]  ext_two = 2'h0;
  logic [1:0]  cmd = 2'h0;
  logic [1:0]  broken = 2'h0;
  logic [1:0]  alarm, active, ext_blocked, not_possible;
  int          n;
  int          miscompares = 0;
  int          n_compared = 0;

  trsv_top #(.TICK_CYCLES(TICK)) u_trsv_top (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digital_in(digital_in),
    .switchgear_one_position(sg_one), .switchgear_two_position(sg_two),
    .external_block_one(ext_one), .external_block_two(ext_two),
    .alarm(alarm), .active(active), .ext_blocked(ext_blocked),
    .not_possible(not_possible), .irq(irq));

  trsv_breaker_model u_trsv_breaker_model (
    .pclk(pclk), .cmd(cmd), .broken(broken),
    .digital_in(digital_in), .sg_one(sg_one), .sg_two(sg_two));

  // ****
  // Shared tasks
  // ****
  task tally_and_finish;
    if (miscompares == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 16);
    if (pready !== 1'b1)
    begin
      check(32'(pready), 32'h1);
      tally_and_finish;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wait_al(input int ch, input logic lvl, input int lim,
    input logic must);
    n = 0;
    while (alarm[ch] !== lvl && n < lim)
    begin
      @(posedge pclk);
      n++;
    end
    // A level that never comes must not slip past the later checks
    if (must && alarm[ch] !== lvl)
    begin
      check(32'(alarm[ch]), 32'(lvl));
      tally_and_finish;
    end
  endtask

  function automatic logic [31:0] cw(input logic m, input logic p,
    input logic [1:0] s, input logic [4:0] i1, input logic [4:0] i2);
    return {17'h0, i2, i1, s, p, m, 1'b1};
  endfunction

  // ****
  // Scenarios
  // ****
  task t_reset;
    apb(1'b0, `TRSV_OFF_CTRL0, 32'h0);
    check(rd, 32'h0);
    apb(1'b0, `TRSV_OFF_DELAY0, 32'h0);
    check(rd, 32'h14);
    apb(1'b0, 12'h01C, 32'h0);
    check(rd, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b1, `TRSV_OFF_DELAY0, 32'h5);
    apb(1'b0, `TRSV_OFF_DELAY0, 32'h0);
    check(rd, 32'hA);
    apb(1'b1, `TRSV_OFF_DELAY0, 32'h7D0);
    apb(1'b0, `TRSV_OFF_DELAY0, 32'h0);
    check(rd, 32'h3E8);
    // Delay well above the model's contact travel time
    apb(1'b1, `TRSV_OFF_DELAY0, 32'hA);
    apb(1'b1, `TRSV_OFF_IRQMSK, 32'hF);
  endtask

  task t_closed;
    cmd <= 2'h1;
    repeat (12) @(posedge pclk);
    apb(1'b1, `TRSV_OFF_CTRL0, cw(1'b0, 1'b0, 2'h1, 5'h01, 5'h00));
    apb(1'b0, `TRSV_OFF_STATUS, 32'h0);
    check(rd, 32'h4);
    cmd <= 2'h0;
    repeat (20) @(posedge pclk);
    cmd <= 2'h1;
    wait_al(0, 1'b1, 3 * DLY, 1'b0);
    check(alarm[0], 1'b0);
    broken <= 2'h1;
    wait_al(0, 1'b1, 2 * DLY, 1'b1);
    check(n >= DLY && n <= DLY + 8, 1'b1);
    repeat (2) @(posedge pclk);
    check(irq, 1'b1);
    broken <= 2'h0;
    wait_al(0, 1'b0, 8, 1'b1);
    check(alarm[0], 1'b0);
    apb(1'b1, `TRSV_OFF_IRQST, 32'h1);
    repeat (2) @(posedge pclk);
    check(irq, 1'b0);
    cmd <= 2'h0;
    broken <= 2'h1;
    wait_al(0, 1'b1, 3 * DLY, 1'b0);
    check(alarm[0], 1'b0);
  endtask

  task t_block;
    cmd <= 2'h1;
    wait_al(0, 1'b1, 3 * DLY, 1'b1);
    ext_one <= 2'h1;
    repeat (6) @(posedge pclk);
    check({ext_blocked[0], alarm[0]}, 2'h1);
    apb(1'b1, `TRSV_OFF_CTRL0, cw(1'b0, 1'b1, 2'h1, 5'h01, 5'h00));
    repeat (4) @(posedge pclk);
    check({ext_blocked[0], alarm[0]}, 2'h2);
    ext_one <= 2'h0;
    ext_two <= 2'h1;
    repeat (6) @(posedge pclk);
    check(ext_blocked[0], 1'b1);
    ext_two <= 2'h0;
    wait_al(0, 1'b1, 3 * DLY, 1'b1);
    check(n >= DLY && n <= DLY + 8, 1'b1);
    apb(1'b1, `TRSV_OFF_CTRL0, 32'h0);
    repeat (2) @(posedge pclk);
    check({active[0], alarm[0]}, 2'h0);
  endtask

  task t_both;
    broken <= 2'h0;
    cmd <= 2'h0;
    repeat (12) @(posedge pclk);
    apb(1'b1, `TRSV_OFF_CTRL0, cw(1'b1, 1'b0, 2'h1, 5'h01, 5'h02));
    wait_al(0, 1'b1, 3 * DLY, 1'b0);
    check(alarm[0], 1'b0);
    broken <= 2'h1;
    wait_al(0, 1'b1, 2 * DLY, 1'b1);
    check(n >= DLY && n <= DLY + 8, 1'b1);
  endtask

  task t_chan2;
    apb(1'b1, `TRSV_OFF_CTRL0, cw(1'b0, 1'b0, 2'h1, 5'h01, 5'h00));
    apb(1'b1, `TRSV_OFF_IRQST, 32'hF);
    apb(1'b1, CTRL1, cw(1'b0, 1'b0, 2'h0, 5'h03, 5'h00));
    repeat (3) @(posedge pclk);
    check({active[1], not_possible[1], irq}, 3'h3);
    cmd <= 2'h2;
    broken <= 2'h3;
    repeat (12) @(posedge pclk);
    apb(1'b1, CTRL1, cw(1'b0, 1'b0, 2'h2, 5'h03, 5'h00));
    wait_al(1, 1'b1, 3 * DLY, 1'b1);
    check(alarm, 2'h2);
    // Channel one still runs on its own reset delay, not channel zero's
    check(n >= DLY1 && n <= DLY1 + 8, 1'b1);
  endtask

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_closed;
    t_block;
    t_both;
    t_chan2;
    tally_and_finish;
  end
endmodule
